// >>> ctts_defs.svh
// Purpose: constants of the conversion and transfer trigger select block
// Assumes: byte addresses on an 8-bit register address port, 32-bit data
// Notes: definitions only
`ifndef CTTS_DEFS_SVH
`define CTTS_DEFS_SVH

// ************************************************************
// register offsets
// ************************************************************
`define CTTS_OFS_CONV1_CFG 8'h00
`define CTTS_OFS_CONV2_CFG 8'h04
`define CTTS_OFS_SER1_SEL 8'h08
`define CTTS_OFS_SER2_SEL 8'h0c
`define CTTS_OFS_SER3_SEL 8'h10
`define CTTS_OFS_SER_POL 8'h14
`define CTTS_OFS_TICK_PERIOD 8'h18
`define CTTS_OFS_SRC_LEVEL 8'h1c

// ************************************************************
// field positions and widths
// ************************************************************
`define CTTS_CONV_SRC_W 3
`define CTTS_TG_SRC_W 4
`define CTTS_TG_SRC_OFF 4'h0
`define CTTS_CONV_CFG_W 12
`define CTTS_TICK_W 16
`define CTTS_SER_POL_LSB1 0
`define CTTS_SER_POL_LSB2 8
`define CTTS_SER_POL_LSB3 16

// ************************************************************
// reset values
// ************************************************************
`define CTTS_RST_CONV_CFG 12'h000
`define CTTS_RST_SER_SEL 32'h0000_0000
`define CTTS_RST_SER_POL 8'h00
`define CTTS_RST_TICK_PERIOD 16'h0000

`endif

// >>> ctts_pkg.sv
// Purpose: types of the conversion and transfer trigger select block
// Assumes: used with ctts_defs.svh
// Notes: nothing is imported, every use is scoped
package ctts_pkg;

    // one converter group: edge select and 3-bit source select
    typedef struct packed {
        logic falling;
        logic [2:0] src;
    } ctts_grp_cfg_s;

    // converter configuration, group 1 in the low nibble
    typedef struct packed {
        ctts_grp_cfg_s ev;
        ctts_grp_cfg_s g2;
        ctts_grp_cfg_s g1;
    } ctts_conv_cfg_s;

    // one start pulse per converter group
    typedef struct packed {
        logic ev;
        logic g2;
        logic g1;
    } ctts_conv_start_s;

    typedef logic [31:0] ctts_word_t;

endpackage : ctts_pkg

// >>> ctts_sync.sv
// Purpose: two-flop synchroniser for a group of level inputs
// Assumes: inputs asynchronous to CLK
// Notes: first stage is read only by the second stage
`timescale 1ns/10ps
module ctts_sync #(
    parameter int W = 1
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    initial begin
        if (W < 1) begin
            $error("ctts_sync: W must be at least 1");
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            meta_r <= '0;
            sync_r <= '0;
        end else if (ce_in) begin
            meta_r <= d_in;
            sync_r <= meta_r;
        end
    end

    assign q_out = sync_r;
endmodule // ctts_sync

// >>> ctts_trig_chan.sv
// Purpose: select one trigger source and turn its chosen edge into a start pulse
// Assumes: sources already in the clock domain
// Notes: a change of select is absorbed without a start
`timescale 1ns/10ps
module ctts_trig_chan #(
    parameter int SEL_W = 3
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    input wire logic [(1<<SEL_W)-1:0] src_in,
    input wire logic [SEL_W-1:0] sel_in,
    input wire logic falling_in,
    input wire logic enable_in,
    output logic start_out
);
    logic [SEL_W-1:0] sel_r;
    logic prev_r;
    logic primed_r;
    logic start_r;
    wire logic level_w = src_in[sel_in];
    wire logic same_sel_w = (sel_in == sel_r);
    wire logic rise_w = level_w & ~prev_r;
    wire logic fall_w = ~level_w & prev_r;
    wire logic edge_w = falling_in ? fall_w : rise_w;
    wire logic start_nxt = enable_in & primed_r & same_sel_w & edge_w;

    initial begin
        if (SEL_W < 1 || SEL_W > 4) begin
            $error("ctts_trig_chan: SEL_W must be 1 to 4");
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            sel_r <= '0;
            prev_r <= 1'b0;
            primed_r <= 1'b0;
            start_r <= 1'b0;
        end else if (ce_in) begin
            sel_r <= sel_in;
            prev_r <= level_w;
            primed_r <= 1'b1;
            start_r <= start_nxt;
        end
    end

    assign start_out = start_r;
endmodule // ctts_trig_chan

// >>> ctts_top.sv
// Purpose: trigger source select and edge qualification for two converters
//          and three buffered serial peripherals
// Assumes: single clock CLK_IN, synchronous active-low reset NRST_IN
// Notes: all trigger inputs pass two flops before selection
//
// How it works
// - converter groups 1, 2 and event can each be started by events
// - each converter group has its own 3-bit source and edge select
// - converter 1 codes: event pin, timer 8,10, compare 0, 17,19, port B 0,1
// - converter 2 uses the same map with its own event pin at code 000
// - every source exists internally whether or not its pin is bonded
// - pin level is observed whether driven externally or by software
// - compare line is high on its event, rising edge starts at assertion
// - falling edge on the compare line starts the group at deassertion
// - each serial instance has transfer groups started by events or the tick
// - 4-bit code: 0 off, 1-8 port A 0-7, 9-14 timer 8..18, 15 tick
// - third serial instance decodes trigger codes like the first
// - second serial instance decodes trigger codes like the first
// - internal tick counter makes periodic starts with no outside stimulus
// - each buffer may serve other dma channels in other transfer groups
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`include "ctts_defs.svh"
`timescale 1ns/10ps
module ctts_top #(
    parameter int NUM_TG = 8
) (
    input wire logic CLK_IN,
    input wire logic NRST_IN,
    input wire logic CE_IN,
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [31:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [31:0] REG_RDATA_OUT,
    input wire logic CONVERTER1_EVENT_PIN_IN,
    input wire logic CONVERTER2_EVENT_PIN_IN,
    input wire logic [7:0] PORT_A_PIN_IN,
    input wire logic [1:0] PORT_B_PIN_IN,
    input wire logic [31:0] HIGH_END_TIMER_CHANNEL_IN,
    input wire logic OS_TICK_TIMER_COMPARE0_IN,
    output ctts_pkg::ctts_conv_start_s CONVERTER1_START_OUT,
    output ctts_pkg::ctts_conv_start_s CONVERTER2_START_OUT,
    output logic [NUM_TG-1:0] SERIAL1_TG_START_OUT,
    output logic [NUM_TG-1:0] SERIAL2_TG_START_OUT,
    output logic [NUM_TG-1:0] SERIAL3_TG_START_OUT
);
    localparam int SEL_BITS = NUM_TG * `CTTS_TG_SRC_W;

    initial begin
        if (NUM_TG < 1 || NUM_TG > 8) begin
            $error("ctts_top: NUM_TG must be 1 to 8 to fit one register word");
        end
    end

    // ************************************************************
    // input synchronisers
    // ************************************************************
    // software-driven output pins are looped back through the same pads,
    // so one path covers both cases
    localparam int RAW_W = 22;
    wire logic [RAW_W-1:0] raw_w = {
        HIGH_END_TIMER_CHANNEL_IN[19],
        HIGH_END_TIMER_CHANNEL_IN[18],
        HIGH_END_TIMER_CHANNEL_IN[17],
        HIGH_END_TIMER_CHANNEL_IN[16],
        HIGH_END_TIMER_CHANNEL_IN[14],
        HIGH_END_TIMER_CHANNEL_IN[12],
        HIGH_END_TIMER_CHANNEL_IN[10],
        HIGH_END_TIMER_CHANNEL_IN[8],
        OS_TICK_TIMER_COMPARE0_IN,
        CONVERTER2_EVENT_PIN_IN,
        CONVERTER1_EVENT_PIN_IN,
        PORT_B_PIN_IN,
        PORT_A_PIN_IN,
        1'b0
    };
    logic [RAW_W-1:0] lvl_w;

    ctts_sync #(
        .W(RAW_W)
    ) u_sync (
        .clk_in(CLK_IN),
        .nrst_in(NRST_IN),
        .ce_in(CE_IN),
        .d_in(raw_w),
        .q_out(lvl_w)
    );

    wire logic [7:0] port_a_w = lvl_w[8:1];
    wire logic [1:0] port_b_w = lvl_w[10:9];
    wire logic conv1_pin_w = lvl_w[11];
    wire logic conv2_pin_w = lvl_w[12];
    wire logic compare0_w = lvl_w[13];
    wire logic tmr8_w = lvl_w[14];
    wire logic tmr10_w = lvl_w[15];
    wire logic tmr12_w = lvl_w[16];
    wire logic tmr14_w = lvl_w[17];
    wire logic tmr16_w = lvl_w[18];
    wire logic tmr17_w = lvl_w[19];
    wire logic tmr18_w = lvl_w[20];
    wire logic tmr19_w = lvl_w[21];

    // ************************************************************
    // registers
    // ************************************************************
    ctts_pkg::ctts_conv_cfg_s conv1_cfg_r;
    ctts_pkg::ctts_conv_cfg_s conv2_cfg_r;
    ctts_pkg::ctts_word_t ser_sel_r [3];
    logic [7:0] ser_pol_r [3];
    logic [`CTTS_TICK_W-1:0] tick_period_r;
    ctts_pkg::ctts_word_t rdata_r;

    wire logic hit_conv1_w = (REG_ADDR_IN == `CTTS_OFS_CONV1_CFG);
    wire logic hit_conv2_w = (REG_ADDR_IN == `CTTS_OFS_CONV2_CFG);
    wire logic hit_ser1_w = (REG_ADDR_IN == `CTTS_OFS_SER1_SEL);
    wire logic hit_ser2_w = (REG_ADDR_IN == `CTTS_OFS_SER2_SEL);
    wire logic hit_ser3_w = (REG_ADDR_IN == `CTTS_OFS_SER3_SEL);
    wire logic hit_pol_w = (REG_ADDR_IN == `CTTS_OFS_SER_POL);
    wire logic hit_tick_w = (REG_ADDR_IN == `CTTS_OFS_TICK_PERIOD);
    wire logic hit_lvl_w = (REG_ADDR_IN == `CTTS_OFS_SRC_LEVEL);
    wire logic [2:0] hit_ser_w = {hit_ser3_w, hit_ser2_w, hit_ser1_w};

    // unused transfer group fields stay zero so they read back as zero
    wire ctts_pkg::ctts_word_t sel_mask_w = (SEL_BITS >= 32) ? 32'hffff_ffff
        : ((32'h0000_0001 << SEL_BITS) - 32'h0000_0001);
    wire logic [7:0] pol_mask_w = sel_mask_w[7:0] | ((NUM_TG >= 8) ? 8'hff : 8'h00);
    wire logic [7:0] pol_mask_tg_w = (NUM_TG >= 8) ? 8'hff
        : 8'((16'h0001 << NUM_TG) - 16'h0001);

    wire logic [20:0] src_level_w = {
        tmr19_w, tmr18_w, tmr17_w, tmr16_w, tmr14_w, tmr12_w, tmr10_w, tmr8_w,
        compare0_w, conv2_pin_w, conv1_pin_w, port_b_w, port_a_w
    };

    wire ctts_pkg::ctts_word_t rd_mux_w =
        hit_conv1_w ? {20'h0_0000, conv1_cfg_r} :
        hit_conv2_w ? {20'h0_0000, conv2_cfg_r} :
        hit_ser1_w ? ser_sel_r[0] :
        hit_ser2_w ? ser_sel_r[1] :
        hit_ser3_w ? ser_sel_r[2] :
        hit_pol_w ? {8'h00, ser_pol_r[2], ser_pol_r[1], ser_pol_r[0]} :
        hit_tick_w ? {16'h0000, tick_period_r} :
        hit_lvl_w ? {11'h000, src_level_w} :
        32'h0000_0000;
    wire ctts_pkg::ctts_word_t rdata_nxt = REG_RD_IN ? rd_mux_w : 32'h0000_0000;

    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            conv1_cfg_r <= `CTTS_RST_CONV_CFG;
            conv2_cfg_r <= `CTTS_RST_CONV_CFG;
            tick_period_r <= `CTTS_RST_TICK_PERIOD;
            rdata_r <= 32'h0000_0000;
        end else if (CE_IN) begin
            if (REG_WR_IN && hit_conv1_w) begin
                conv1_cfg_r <= REG_WDATA_IN[`CTTS_CONV_CFG_W-1:0];
            end
            if (REG_WR_IN && hit_conv2_w) begin
                conv2_cfg_r <= REG_WDATA_IN[`CTTS_CONV_CFG_W-1:0];
            end
            if (REG_WR_IN && hit_tick_w) begin
                tick_period_r <= REG_WDATA_IN[`CTTS_TICK_W-1:0];
            end
            rdata_r <= rdata_nxt;
        end
    end

    for (genvar s = 0; s < 3; s++) begin : g_ser_regs
        always_ff @(posedge CLK_IN) begin
            if (!NRST_IN) begin
                ser_sel_r[s] <= `CTTS_RST_SER_SEL;
                ser_pol_r[s] <= `CTTS_RST_SER_POL;
            end else if (CE_IN) begin
                if (REG_WR_IN && hit_ser_w[s]) begin
                    ser_sel_r[s] <= REG_WDATA_IN & sel_mask_w;
                end
                if (REG_WR_IN && hit_pol_w) begin
                    ser_pol_r[s] <= REG_WDATA_IN[8*s +: 8] & pol_mask_tg_w;
                end
            end
        end
    end

    assign REG_RDATA_OUT = rdata_r;

    // ************************************************************
    // internal tick counter
    // ************************************************************
    // period zero stops the tick; a period of n gives one tick every n cycles
    logic [`CTTS_TICK_W-1:0] tick_cnt_r;
    logic tick_r;
    wire logic tick_run_w = (tick_period_r != `CTTS_RST_TICK_PERIOD);
    wire logic tick_wrap_w = (tick_cnt_r >= (tick_period_r - `CTTS_TICK_W'(1)));
    wire logic [`CTTS_TICK_W-1:0] tick_cnt_nxt = !tick_run_w ? '0
        : tick_wrap_w ? '0 : tick_cnt_r + `CTTS_TICK_W'(1);
    wire logic tick_nxt = tick_run_w & tick_wrap_w;

    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            tick_cnt_r <= '0;
            tick_r <= 1'b0;
        end else if (CE_IN) begin
            tick_cnt_r <= tick_cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    // ************************************************************
    // converter trigger selection
    // ************************************************************
    // code order is the source index, so the select drives the mux directly
    wire logic [7:0] conv_common_w = {
        port_b_w[1], port_b_w[0], tmr19_w, tmr17_w, compare0_w, tmr10_w, tmr8_w, 1'b0
    };
    wire logic [7:0] conv1_src_w = {conv_common_w[7:1], conv1_pin_w};
    wire logic [7:0] conv2_src_w = {conv_common_w[7:1], conv2_pin_w};
    wire ctts_pkg::ctts_grp_cfg_s conv_grp_w [2][3];
    wire logic [7:0] conv_src_w [2];
    logic [2:0] conv_start_w [2];

    assign conv_src_w[0] = conv1_src_w;
    assign conv_src_w[1] = conv2_src_w;
    assign conv_grp_w[0][0] = conv1_cfg_r.g1;
    assign conv_grp_w[0][1] = conv1_cfg_r.g2;
    assign conv_grp_w[0][2] = conv1_cfg_r.ev;
    assign conv_grp_w[1][0] = conv2_cfg_r.g1;
    assign conv_grp_w[1][1] = conv2_cfg_r.g2;
    assign conv_grp_w[1][2] = conv2_cfg_r.ev;

    for (genvar c = 0; c < 2; c++) begin : g_conv
        for (genvar g = 0; g < 3; g++) begin : g_grp
            ctts_trig_chan #(
                .SEL_W(`CTTS_CONV_SRC_W)
            ) u_chan (
                .clk_in(CLK_IN),
                .nrst_in(NRST_IN),
                .ce_in(CE_IN),
                .src_in(conv_src_w[c]),
                .sel_in(conv_grp_w[c][g].src),
                .falling_in(conv_grp_w[c][g].falling),
                .enable_in(1'b1),
                .start_out(conv_start_w[c][g])
            );
        end
    end

    assign CONVERTER1_START_OUT = conv_start_w[0];
    assign CONVERTER2_START_OUT = conv_start_w[1];

    // ************************************************************
    // transfer group trigger selection
    // ************************************************************
    // all three serial instances share one source vector and one decode
    wire logic [15:0] tg_src_w = {
        tick_r, tmr18_w, tmr16_w, tmr14_w, tmr12_w, tmr10_w, tmr8_w, port_a_w, 1'b0
    };
    logic [NUM_TG-1:0] tg_start_w [3];

    for (genvar s = 0; s < 3; s++) begin : g_ser
        for (genvar k = 0; k < NUM_TG; k++) begin : g_tg
            wire logic [3:0] tg_sel_w = ser_sel_r[s][4*k +: 4];
            ctts_trig_chan #(
                .SEL_W(`CTTS_TG_SRC_W)
            ) u_chan (
                .clk_in(CLK_IN),
                .nrst_in(NRST_IN),
                .ce_in(CE_IN),
                .src_in(tg_src_w),
                .sel_in(tg_sel_w),
                .falling_in(ser_pol_r[s][k]),
                .enable_in(tg_sel_w != `CTTS_TG_SRC_OFF),
                .start_out(tg_start_w[s][k])
            );
        end
    end

    // each start is per transfer group; the buffer-to-dma pairing lives
    // in the serial scheduler, which may reuse a buffer across groups
    assign SERIAL1_TG_START_OUT = tg_start_w[0];
    assign SERIAL2_TG_START_OUT = tg_start_w[1];
    assign SERIAL3_TG_START_OUT = tg_start_w[2];

    // pol_mask_w kept equal to the per-group mask for wide configurations
    wire logic unused_w = ^pol_mask_w;
endmodule // ctts_top

// >>> ctts_src_model.sv
// Purpose: far-side model of the trigger sources: pins, timer channels, compare line
// Assumes: the bench changes levels only through set_level
// Notes: every level is held until told otherwise, as a real pin or timer would
`timescale 1ns/10ps
module ctts_src_model (
    input wire logic clk_in,
    output logic conv1_pin_out,
    output logic conv2_pin_out,
    output logic [7:0] port_a_out,
    output logic [1:0] port_b_out,
    output logic [31:0] timer_out,
    output logic compare0_out
);
    // ************************************************************
    // source levels: 0-7 port A, 8-9 port B, 10-11 event pins, 12 compare, 13+n timer n
    // ************************************************************
    logic [44:0] lvl_r = 45'h0;

    // a pin driven from outside or from its own output latch looks the same here
    task automatic set_level(input int idx, input logic v);
        @(posedge clk_in);
        lvl_r[idx] <= v;
    endtask

    assign port_a_out = lvl_r[7:0];
    assign port_b_out = lvl_r[9:8];
    assign conv1_pin_out = lvl_r[10];
    assign conv2_pin_out = lvl_r[11];
    // compare line is high while its event is pending
    assign compare0_out = lvl_r[12];
    assign timer_out = lvl_r[44:13];
endmodule // ctts_src_model

// >>> ctts_top_props.sv
// Purpose: port-level checks of the trigger select block
// Assumes: ctts_pkg compiled first
// Notes: config shadows are rebuilt from observed register writes
`timescale 1ns/10ps
module ctts_top_props #(
    parameter int NUM_TG = 8
) (
    input wire logic CLK_IN,
    input wire logic NRST_IN,
    input wire logic CE_IN,
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [31:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [31:0] REG_RDATA_OUT,
    input wire logic CONVERTER1_EVENT_PIN_IN,
    input wire logic [7:0] PORT_A_PIN_IN,
    input wire logic OS_TICK_TIMER_COMPARE0_IN,
    input wire ctts_pkg::ctts_conv_start_s CONVERTER1_START_OUT,
    input wire ctts_pkg::ctts_conv_start_s CONVERTER2_START_OUT,
    input wire logic [NUM_TG-1:0] SERIAL1_TG_START_OUT,
    input wire logic [NUM_TG-1:0] SERIAL2_TG_START_OUT
);
    // ************************************************************
    // shadow state
    // ************************************************************
    logic [11:0] c1_r;
    logic [11:0] c2_r;
    logic [3:0] s1_r;
    logic p1_r;
    logic [7:0] age_r;
    logic settled;
    // a fresh select swallows edges, so checks wait out the whole pipeline
    assign settled = age_r >= 8'h08;
    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN || !CE_IN || REG_WR_IN) begin
            age_r <= 8'h00;
        end else if (age_r != 8'hff) begin
            age_r <= age_r + 8'h01;
        end
    end
    always_ff @(posedge CLK_IN) begin
        if (!NRST_IN) begin
            c1_r <= 12'h000;
            c2_r <= 12'h000;
            s1_r <= 4'h0;
            p1_r <= 1'b0;
        end else if (REG_WR_IN && CE_IN) begin
            if (REG_ADDR_IN == 8'h00) c1_r <= REG_WDATA_IN[11:0];
            if (REG_ADDR_IN == 8'h04) c2_r <= REG_WDATA_IN[11:0];
            if (REG_ADDR_IN == 8'h08) s1_r <= REG_WDATA_IN[3:0];
            if (REG_ADDR_IN == 8'h14) p1_r <= REG_WDATA_IN[0];
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!NRST_IN);

    pin_rise_start_a: assert property (
        settled && c1_r[3:0] == 4'h0 && $past(CONVERTER1_EVENT_PIN_IN, 3)
        && !$past(CONVERTER1_EVENT_PIN_IN, 4) |-> CONVERTER1_START_OUT.g1)
        else $error("converter 1 group 1 missed a pin rise");
    start_has_cause_a: assert property (
        settled && c1_r[3:0] == 4'h0 && CONVERTER1_START_OUT.g1
        |-> $past(CONVERTER1_EVENT_PIN_IN, 3) && !$past(CONVERTER1_EVENT_PIN_IN, 4))
        else $error("converter 1 group 1 start without a pin rise");
    start_one_cycle_a: assert property (
        CONVERTER1_START_OUT.g1 && CE_IN |=> !CONVERTER1_START_OUT.g1)
        else $error("converter start longer than one cycle");
    cmp_rise_start_a: assert property (
        settled && c1_r[7:4] == 4'h3 && $past(OS_TICK_TIMER_COMPARE0_IN, 3)
        && !$past(OS_TICK_TIMER_COMPARE0_IN, 4) |-> CONVERTER1_START_OUT.g2)
        else $error("compare assertion did not start group 2");
    cmp_fall_start_a: assert property (
        settled && c2_r[11:8] == 4'hb && !$past(OS_TICK_TIMER_COMPARE0_IN, 3)
        && $past(OS_TICK_TIMER_COMPARE0_IN, 4) |-> CONVERTER2_START_OUT.ev)
        else $error("compare release did not start the event group");
    tg_off_quiet_a: assert property (
        settled && s1_r == 4'h0 |-> !SERIAL1_TG_START_OUT[0])
        else $error("disabled transfer group started");
    tg_port_start_a: assert property (
        settled && s1_r == 4'h1 && !p1_r && $past(PORT_A_PIN_IN[0], 3)
        && !$past(PORT_A_PIN_IN[0], 4) |-> SERIAL1_TG_START_OUT[0])
        else $error("transfer group missed a port pin rise");
    tg_one_cycle_a: assert property (
        SERIAL2_TG_START_OUT[0] && CE_IN |=> !SERIAL2_TG_START_OUT[0])
        else $error("transfer group start longer than one cycle");
    rdata_idle_zero_a: assert property (
        !REG_RD_IN && CE_IN |=> REG_RDATA_OUT == 32'h0000_0000)
        else $error("read data not zero outside a read");

    cover property (CONVERTER1_START_OUT.g1);
    cover property (CONVERTER2_START_OUT.ev);
    cover property (SERIAL2_TG_START_OUT[0]);
endmodule // ctts_top_props

bind ctts_top ctts_top_props #(.NUM_TG(NUM_TG)) u_props (
    .CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .CE_IN(CE_IN), .REG_ADDR_IN(REG_ADDR_IN),
    .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
    .REG_RDATA_OUT(REG_RDATA_OUT), .CONVERTER1_EVENT_PIN_IN(CONVERTER1_EVENT_PIN_IN),
    .PORT_A_PIN_IN(PORT_A_PIN_IN), .OS_TICK_TIMER_COMPARE0_IN(OS_TICK_TIMER_COMPARE0_IN),
    .CONVERTER1_START_OUT(CONVERTER1_START_OUT), .CONVERTER2_START_OUT(CONVERTER2_START_OUT),
    .SERIAL1_TG_START_OUT(SERIAL1_TG_START_OUT), .SERIAL2_TG_START_OUT(SERIAL2_TG_START_OUT)
);

// >>> ctts_top_tb.sv
// Purpose: self-checking bench of the trigger select block
// Assumes: CE_IN held high; start pulses counted per output bit
// Notes: every source is pulsed long enough for both edges to pass the synchroniser
`timescale 1ns/10ps
module ctts_top_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] rdata, got, v;
    logic c1_pin, c2_pin, cmp;
    logic [7:0] pa;
    logic [1:0] pb;
    logic [31:0] tmr;
    ctts_pkg::ctts_conv_start_s c1_st, c2_st;
    logic [7:0] s1_st, s2_st, s3_st;
    logic [29:0] starts;
    int cnt[30];
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int conv_idx[8] = '{10, 21, 23, 12, 30, 32, 8, 9};
    logic [31:0] msk[7] = '{32'h0fff, 32'h0fff, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff,
        32'h00ff_ffff, 32'h0000_ffff};

    always #4 clk = ~clk;

    ctts_top dut (.CLK_IN(clk), .NRST_IN(nrst), .CE_IN(ce), .REG_ADDR_IN(reg_addr),
        .REG_WDATA_IN(reg_wdata), .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd), .REG_RDATA_OUT(rdata),
        .CONVERTER1_EVENT_PIN_IN(c1_pin), .CONVERTER2_EVENT_PIN_IN(c2_pin), .PORT_A_PIN_IN(pa),
        .PORT_B_PIN_IN(pb), .HIGH_END_TIMER_CHANNEL_IN(tmr), .OS_TICK_TIMER_COMPARE0_IN(cmp),
        .CONVERTER1_START_OUT(c1_st), .CONVERTER2_START_OUT(c2_st),
        .SERIAL1_TG_START_OUT(s1_st), .SERIAL2_TG_START_OUT(s2_st), .SERIAL3_TG_START_OUT(s3_st));
    ctts_src_model src (.clk_in(clk), .conv1_pin_out(c1_pin), .conv2_pin_out(c2_pin),
        .port_a_out(pa), .port_b_out(pb), .timer_out(tmr), .compare0_out(cmp));

    // ************************************************************
    // pulse counting and hang guard
    // ************************************************************
    assign starts = {s3_st, s2_st, s1_st, c2_st, c1_st};
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            fail_count++;
            end_sim();
        end
        for (int i = 0; i < 30; i++) if (nrst && starts[i] === 1'b1) cnt[i]++;
    end

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic end_sim();
        if (fail_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic chk_cnt(input int lo, input int hi, input int e);
        for (int i = lo; i <= hi; i++) chk($sformatf("start %0d", i), 32'(cnt[i]), 32'(e));
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    // counting window of exactly n rising edges
    task automatic win(input int n);
        @(negedge clk);
        foreach (cnt[i]) cnt[i] = 0;
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic pulse(input int i);
        @(negedge clk);
        foreach (cnt[k]) cnt[k] = 0;
        src.set_level(i, 1'b1);
        repeat (4) @(posedge clk);
        src.set_level(i, 1'b0);
        repeat (8) @(posedge clk);
        @(negedge clk);
    endtask

    // ************************************************************
    // sequence
    // ************************************************************
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        bus_wr(8'h20, 32'hffff_ffff);
        for (int a = 0; a <= 32; a += 4) begin
            bus_rd(a[7:0], got);
            chk("reset value", got, 32'h0000_0000);
        end
        for (int i = 0; i < 7; i++) begin
            bus_wr(8'(i * 4), 32'hffff_ffff);
            bus_rd(8'(i * 4), got);
            chk("readback", got, msk[i]);
            bus_wr(8'(i * 4), 32'h0000_0000);
        end
        src.set_level(0, 1'b1);
        src.set_level(12, 1'b1);
        src.set_level(32, 1'b1);
        repeat (4) @(posedge clk);
        bus_rd(8'h1c, got);
        chk("levels", got, 32'h0010_1001);
        src.set_level(0, 1'b0);
        src.set_level(12, 1'b0);
        src.set_level(32, 1'b0);
        repeat (8) @(posedge clk);
        for (int c = 0; c < 8; c++) begin
            v = {20'h0, 1'b0, c[2:0], 1'b0, c[2:0], 1'b0, c[2:0]};
            bus_wr(8'h00, v);
            bus_wr(8'h04, v);
            repeat (8) @(posedge clk);
            pulse(conv_idx[c]);
            chk_cnt(0, 2, 1);
            chk_cnt(3, 5, c == 0 ? 0 : 1);
            if (c == 0) begin
                pulse(11);
                chk_cnt(0, 2, 0);
                chk_cnt(3, 5, 1);
            end
        end
        bus_wr(8'h00, 32'h0000_00b3);
        bus_wr(8'h04, 32'h0000_0b00);
        repeat (8) @(posedge clk);
        pulse(12);
        chk("rise group 1", 32'(cnt[0]), 32'h1);
        chk("fall group 2", 32'(cnt[1]), 32'h1);
        chk("fall event 2", 32'(cnt[5]), 32'h1);
        for (int c = 0; c < 15; c++) begin
            v = {8{c[3:0]}};
            bus_wr(8'h08, v);
            bus_wr(8'h0c, v);
            bus_wr(8'h10, v);
            repeat (8) @(posedge clk);
            pulse(c == 0 ? 0 : (c <= 8 ? c - 1 : 21 + 2 * (c - 9)));
            chk_cnt(6, 29, c == 0 ? 0 : 1);
        end
        for (int s = 8; s <= 16; s += 4) bus_wr(8'(s), 32'hffff_ffff);
        bus_wr(8'h14, 32'h0000_ff00);
        bus_wr(8'h18, 32'h0000_000a);
        repeat (20) @(posedge clk);
        win(100);
        chk_cnt(6, 29, 10);
        bus_wr(8'h18, 32'h0000_0000);
        repeat (20) @(posedge clk);
        win(50);
        chk_cnt(6, 29, 0);
        end_sim();
    end
endmodule // ctts_top_tb
